// [common/ats_cfg.svh]
`ifndef ATS_CFG_SVH
`define ATS_CFG_SVH

`define ATS_CLK_MHZ 100
`define ATS_ADDR_W 8
`define ATS_SAMP_W 12
`define ATS_CNT_W 20
`define ATS_TAPS 8
`define ATS_COEF_W 16
// Register byte addresses
`define ATS_A_CTRL 8'h00
`define ATS_A_TRIG 8'h04
`define ATS_A_LEVEL 8'h08
`define ATS_A_RECLEN 8'h0c
`define ATS_A_REFPOS 8'h10
`define ATS_A_NREC 8'h14
`define ATS_A_HOLDOFF 8'h18
`define ATS_A_DELAY 8'h1c
`define ATS_A_BW 8'h20
`define ATS_A_EQ 8'h24
`define ATS_A_STATUS 8'h28
`define ATS_A_COEF 8'h40
// Field positions in CTRL
`define ATS_CTRL_INIT 0
`define ATS_CTRL_ABORT 1
`define ATS_CTRL_RTONLY 2
`define ATS_CTRL_ETS 3
// Field positions in TRIG
`define ATS_TRIG_MODE_LSB 0
`define ATS_TRIG_SLOPE 2
`define ATS_TRIG_START_IMM 3
`define ATS_TRIG_ADV_IMM 4
// Field position in LEVEL
`define ATS_LEVEL_HYST_LSB 16
// Reset values, percent full scale, bandwidth settings and response codes
`define ATS_RST_CTRL 32'h0000_0004
`define ATS_RST_TRIG 32'h0000_0018
`define ATS_RST_RECLEN 20'h003e8
`define ATS_RST_REFPOS 7'h32
`define ATS_RST_NREC 16'h0001
`define ATS_PCT_FULL 7'h64
`define ATS_BW_DEFAULT 32'h0000_0000
`define ATS_BW_FULL 32'hffff_ffff
`define ATS_RESP_OKAY 2'h0
`define ATS_RESP_SLVERR 2'h2

`endif

// [common/ats_pkg.sv]
package ats_pkg;
    typedef enum logic [1:0] {
        ATS_TRG_IMMEDIATE = 2'h0,
        ATS_TRG_DIGITAL = 2'h1,
        ATS_TRG_EDGE = 2'h2,
        ATS_TRG_HYST = 2'h3
    } ats_mode_t;
    typedef enum logic [1:0] {
        ATS_ST_UNKNOWN = 2'h0,
        ATS_ST_IN_PROGRESS = 2'h1,
        ATS_ST_COMPLETE = 2'h2
    } ats_status_t;
    typedef enum logic [2:0] {
        ATS_IDLE = 3'h0,
        ATS_WAIT_START = 3'h1,
        ATS_PRE = 3'h2,
        ATS_WAIT_REF = 3'h3,
        ATS_DELAY = 3'h4,
        ATS_POST = 3'h5,
        ATS_WAIT_ADV = 3'h6,
        ATS_DONE = 3'h7
    } ats_state_t;
endpackage

// [core/ats_sequencer.sv]
`timescale 1ns/100ps
`include "ats_cfg.svh"

// Overview of operation
// - After initiate, wait for the chosen start trigger (immediate by default).
// - Start trigger begins pretrigger sample capture.
// - Reference trigger is watched only after all pretrigger samples are taken.
// - Reference trigger leads to posttrigger capture, then acquisition complete.
// - Records after the first start on advance trigger until count reached.
// - Pre/post split follows reference position percent, default fifty.
// - Digital trigger mode is refused while equivalent-time sampling selected.
// - Edge and hysteresis detectors fire on rising or falling per slope.
// - After a reference trigger, further triggers ignored until holdoff elapses.
// - After a reference trigger, wait the delay before acquiring posttrigger data.
// - Hysteresis fires only after band crossing then threshold crossing.
// - Immediate mode generates the trigger internally.
// - Realtime-only flag (default set) forbids equivalent-time acquisition.
// - Bandwidth value 0 selects default, -1 selects full.
// - Equalization filter runs only when enabled; tap count readable.
// - Abort stops acquisition and returns to idle.
// - Status reports complete, in progress or unknown.
module ats_sequencer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // AXI4-Lite slave
    input wire logic [`ATS_ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [`ATS_ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Sample stream and trigger inputs
    input wire logic [`ATS_SAMP_W-1:0] i_sample,
    input wire logic i_dig_trig,
    // Capture outputs
    output logic o_capture,
    output logic [`ATS_SAMP_W-1:0] o_eq_sample,
    output logic o_record_done,
    output ats_pkg::ats_status_t o_status
);
    import ats_pkg::*;

    logic [31:0] ctrl_reg;
    logic [31:0] trig_reg;
    logic [`ATS_SAMP_W-1:0] level_reg;
    logic [`ATS_SAMP_W-1:0] hyst_reg;
    logic [`ATS_CNT_W-1:0] reclen_reg;
    logic [6:0] refpos_reg;
    logic [15:0] nrec_reg;
    logic [`ATS_CNT_W-1:0] holdoff_reg;
    logic [`ATS_CNT_W-1:0] delay_reg;
    logic [31:0] bw_reg;
    logic eq_en_reg;
    logic [`ATS_COEF_W-1:0] coef_reg [`ATS_TAPS];
    logic init_reg;
    logic abort_reg;
    logic [`ATS_ADDR_W-1:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic w_held_reg;
    logic mode_err_reg;

    ats_mode_t mode;
    logic ets_allowed;
    logic wr_fire;
    assign mode = ats_mode_t'(trig_reg[`ATS_TRIG_MODE_LSB +: 2]);
    assign ets_allowed = ctrl_reg[`ATS_CTRL_ETS] & ~ctrl_reg[`ATS_CTRL_RTONLY];

    // AXI write: address and data taken in any order
    assign o_awready = ~aw_held_reg & ~o_bvalid;
    assign o_wready = ~w_held_reg & ~o_bvalid;
    assign wr_fire = aw_held_reg & w_held_reg & ~o_bvalid;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            o_bvalid <= 1'b0;
            o_bresp <= `ATS_RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= i_wdata;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (awaddr_reg <= `ATS_A_BW || awaddr_reg == `ATS_A_EQ ||
                    (awaddr_reg >= `ATS_A_COEF &&
                     awaddr_reg < `ATS_A_COEF + 8'(4 * `ATS_TAPS))) ?
                    `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Register writes
    always_ff @(posedge i_clk)
    begin
        init_reg <= 1'b0;
        abort_reg <= 1'b0;
        mode_err_reg <= mode_err_reg;
        if (i_reset)
        begin
            ctrl_reg <= `ATS_RST_CTRL;
            trig_reg <= `ATS_RST_TRIG;
            level_reg <= '0;
            hyst_reg <= '0;
            reclen_reg <= `ATS_RST_RECLEN;
            refpos_reg <= `ATS_RST_REFPOS;
            nrec_reg <= `ATS_RST_NREC;
            holdoff_reg <= '0;
            delay_reg <= '0;
            bw_reg <= `ATS_BW_DEFAULT;
            eq_en_reg <= 1'b0;
            mode_err_reg <= 1'b0;
            for (int i = 0; i < `ATS_TAPS; i++)
                coef_reg[i] <= '0;
        end
        else if (wr_fire)
        begin
            unique case (awaddr_reg)
                `ATS_A_CTRL:
                begin
                    ctrl_reg <= wdata_reg;
                    init_reg <= wdata_reg[`ATS_CTRL_INIT];
                    abort_reg <= wdata_reg[`ATS_CTRL_ABORT];
                end
                `ATS_A_TRIG:
                begin
                    // Digital mode refused under equivalent-time sampling
                    if (ats_mode_t'(wdata_reg[`ATS_TRIG_MODE_LSB +: 2]) == ATS_TRG_DIGITAL
                        && ets_allowed)
                        mode_err_reg <= 1'b1;
                    else
                    begin
                        trig_reg <= wdata_reg;
                        mode_err_reg <= 1'b0;
                    end
                end
                `ATS_A_LEVEL:
                begin
                    level_reg <= wdata_reg[`ATS_SAMP_W-1:0];
                    hyst_reg <= wdata_reg[`ATS_LEVEL_HYST_LSB +: `ATS_SAMP_W];
                end
                `ATS_A_RECLEN: reclen_reg <= wdata_reg[`ATS_CNT_W-1:0];
                `ATS_A_REFPOS: refpos_reg <= (wdata_reg[6:0] > `ATS_PCT_FULL) ?
                    `ATS_PCT_FULL : wdata_reg[6:0];
                `ATS_A_NREC: nrec_reg <= wdata_reg[15:0];
                `ATS_A_HOLDOFF: holdoff_reg <= wdata_reg[`ATS_CNT_W-1:0];
                `ATS_A_DELAY: delay_reg <= wdata_reg[`ATS_CNT_W-1:0];
                `ATS_A_BW: bw_reg <= wdata_reg;
                `ATS_A_EQ: eq_en_reg <= wdata_reg[0];
                default:
                    if (awaddr_reg >= `ATS_A_COEF &&
                        awaddr_reg < `ATS_A_COEF + 8'(4 * `ATS_TAPS))
                        coef_reg[3'(awaddr_reg[4:2])] <= wdata_reg[`ATS_COEF_W-1:0];
            endcase
        end
    end

    // Sample pipeline and trigger detection
    logic signed [`ATS_SAMP_W-1:0] samp_reg;
    logic signed [`ATS_SAMP_W-1:0] prev_reg;
    logic dig_s1_reg;
    logic dig_s2_reg;
    logic dig_prev_reg;
    logic armed_reg;
    logic raw_trig;
    logic signed [`ATS_SAMP_W-1:0] lvl;
    logic signed [`ATS_SAMP_W-1:0] hys;
    logic slope_pos;
    assign lvl = level_reg;
    assign hys = hyst_reg;
    assign slope_pos = ~trig_reg[`ATS_TRIG_SLOPE];
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            samp_reg <= '0;
            prev_reg <= '0;
            dig_s1_reg <= 1'b0;
            dig_s2_reg <= 1'b0;
            dig_prev_reg <= 1'b0;
        end
        else
        begin
            samp_reg <= i_sample;
            prev_reg <= samp_reg;
            dig_s1_reg <= i_dig_trig;
            dig_s2_reg <= dig_s1_reg;
            dig_prev_reg <= dig_s2_reg;
        end
    end

    // Hysteresis arming: band boundary crossed first
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            armed_reg <= 1'b0;
        // Arming left over from another mode must not count
        else if (raw_trig || mode != ATS_TRG_HYST)
            armed_reg <= 1'b0;
        else if (slope_pos ? (samp_reg < lvl - hys) : (samp_reg > lvl + hys))
            armed_reg <= 1'b1;
    end

    always_comb
    begin
        unique case (mode)
            ATS_TRG_IMMEDIATE: raw_trig = 1'b1;
            ATS_TRG_DIGITAL: raw_trig = slope_pos ? (dig_s2_reg & ~dig_prev_reg) :
                (~dig_s2_reg & dig_prev_reg);
            ATS_TRG_EDGE: raw_trig = slope_pos ? (prev_reg < lvl && samp_reg >= lvl) :
                (prev_reg > lvl && samp_reg <= lvl);
            ATS_TRG_HYST: raw_trig = armed_reg && (slope_pos ?
                (prev_reg < lvl && samp_reg >= lvl) :
                (prev_reg > lvl && samp_reg <= lvl));
        endcase
    end

    // Sequencer
    ats_state_t state_reg;
    logic [`ATS_CNT_W-1:0] cnt_reg;
    logic [`ATS_CNT_W-1:0] hold_cnt_reg;
    logic [15:0] rec_cnt_reg;
    logic [`ATS_CNT_W-1:0] pre_len;
    logic [`ATS_CNT_W-1:0] post_len;
    logic trig;
    logic [`ATS_CNT_W+6:0] prod;
    assign prod = reclen_reg * refpos_reg;
    assign pre_len = `ATS_CNT_W'(prod / `ATS_PCT_FULL);
    assign post_len = reclen_reg - pre_len;
    assign trig = raw_trig && hold_cnt_reg == '0;

    // Holdoff counter
    always_ff @(posedge i_clk)
    begin
        if (i_reset || abort_reg)
            hold_cnt_reg <= '0;
        else if (trig && state_reg == ATS_WAIT_REF)
            hold_cnt_reg <= holdoff_reg;
        else if (hold_cnt_reg != '0)
            hold_cnt_reg <= hold_cnt_reg - 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        o_record_done <= 1'b0;
        if (i_reset || abort_reg)
        begin
            state_reg <= ATS_IDLE;
            cnt_reg <= '0;
            rec_cnt_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                ATS_IDLE, ATS_DONE:
                    if (init_reg && !(ets_allowed && mode == ATS_TRG_DIGITAL))
                    begin
                        state_reg <= ATS_WAIT_START;
                        rec_cnt_reg <= '0;
                    end
                ATS_WAIT_START:
                    if (trig_reg[`ATS_TRIG_START_IMM] || trig)
                    begin
                        state_reg <= ATS_PRE;
                        cnt_reg <= pre_len;
                    end
                ATS_PRE:
                    if (cnt_reg == '0)
                        state_reg <= ATS_WAIT_REF;
                    else
                        cnt_reg <= cnt_reg - 1'b1;
                ATS_WAIT_REF:
                    if (trig)
                    begin
                        state_reg <= ATS_DELAY;
                        cnt_reg <= delay_reg;
                    end
                ATS_DELAY:
                    if (cnt_reg == '0)
                    begin
                        state_reg <= ATS_POST;
                        cnt_reg <= post_len;
                    end
                    else
                        cnt_reg <= cnt_reg - 1'b1;
                ATS_POST:
                    if (cnt_reg == '0)
                    begin
                        o_record_done <= 1'b1;
                        rec_cnt_reg <= rec_cnt_reg + 1'b1;
                        state_reg <= (rec_cnt_reg + 1'b1 >= nrec_reg) ?
                            ATS_DONE : ATS_WAIT_ADV;
                    end
                    else
                        cnt_reg <= cnt_reg - 1'b1;
                ATS_WAIT_ADV:
                    if (trig_reg[`ATS_TRIG_ADV_IMM] || trig)
                    begin
                        state_reg <= ATS_PRE;
                        cnt_reg <= pre_len;
                    end
            endcase
        end
    end

    // Capture strobe and equalizer
    logic signed [`ATS_SAMP_W+`ATS_COEF_W+2:0] acc;
    logic signed [`ATS_SAMP_W-1:0] tap_reg [`ATS_TAPS];
    always_comb
    begin
        acc = '0;
        for (int i = 0; i < `ATS_TAPS; i++)
            acc = acc + tap_reg[i] * $signed(coef_reg[i]);
    end
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_capture <= 1'b0;
            o_eq_sample <= '0;
            for (int i = 0; i < `ATS_TAPS; i++)
                tap_reg[i] <= '0;
        end
        else
        begin
            o_capture <= (state_reg == ATS_PRE && cnt_reg != '0) ||
                (state_reg == ATS_POST && cnt_reg != '0);
            tap_reg[0] <= samp_reg;
            for (int i = 1; i < `ATS_TAPS; i++)
                tap_reg[i] <= tap_reg[i-1];
            o_eq_sample <= eq_en_reg ? acc[`ATS_COEF_W-1 +: `ATS_SAMP_W] : samp_reg;
        end
    end

    always_comb
    begin
        unique case (state_reg)
            ATS_IDLE: o_status = ATS_ST_UNKNOWN;
            ATS_DONE: o_status = ATS_ST_COMPLETE;
            default: o_status = ATS_ST_IN_PROGRESS;
        endcase
    end

    // AXI read
    assign o_arready = ~o_rvalid;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= `ATS_RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_rvalid <= 1'b1;
            o_rresp <= `ATS_RESP_OKAY;
            unique case (i_araddr)
                `ATS_A_CTRL: o_rdata <= ctrl_reg;
                `ATS_A_TRIG: o_rdata <= trig_reg;
                `ATS_A_LEVEL: o_rdata <= {4'h0, hyst_reg, 4'h0, level_reg};
                `ATS_A_RECLEN: o_rdata <= 32'(reclen_reg);
                `ATS_A_REFPOS: o_rdata <= 32'(refpos_reg);
                `ATS_A_NREC: o_rdata <= 32'(nrec_reg);
                `ATS_A_HOLDOFF: o_rdata <= 32'(holdoff_reg);
                `ATS_A_DELAY: o_rdata <= 32'(delay_reg);
                `ATS_A_BW: o_rdata <= bw_reg;
                `ATS_A_EQ: o_rdata <= {16'(`ATS_TAPS), 15'h0, eq_en_reg};
                `ATS_A_STATUS: o_rdata <= {rec_cnt_reg, 12'h0, mode_err_reg,
                    state_reg == ATS_PRE, o_status};
                default:
                begin
                    o_rdata <= '0;
                    o_rresp <= `ATS_RESP_SLVERR;
                end
            endcase
        end
        else if (i_rready)
            o_rvalid <= 1'b0;
    end

    // Checks
    property p_abort_idle;
        @(posedge i_clk) disable iff (i_reset) abort_reg |=> state_reg == ATS_IDLE;
    endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("abort not idle");
    property p_ref_after_pre;
        @(posedge i_clk) disable iff (i_reset)
        state_reg == ATS_DELAY |-> $past(state_reg) inside {ATS_WAIT_REF, ATS_DELAY};
    endproperty
    a_ref_after_pre: assert property (p_ref_after_pre) else $error("ref early");
    property p_holdoff;
        @(posedge i_clk) disable iff (i_reset || abort_reg)
        hold_cnt_reg != '0 && state_reg == ATS_WAIT_ADV && !trig_reg[`ATS_TRIG_ADV_IMM]
        |=> state_reg == ATS_WAIT_ADV;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("trigger in holdoff");
    property p_status;
        @(posedge i_clk) disable iff (i_reset || abort_reg)
        state_reg == ATS_POST && cnt_reg == '0 && rec_cnt_reg + 16'h1 >= nrec_reg
        |=> o_status == ATS_ST_COMPLETE;
    endproperty
    a_status: assert property (p_status) else $error("status wrong");
    property p_imm;
        @(posedge i_clk) disable iff (i_reset) mode == ATS_TRG_IMMEDIATE |-> raw_trig;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate idle");
    property p_dig_refused;
        @(posedge i_clk) disable iff (i_reset) ets_allowed |-> mode != ATS_TRG_DIGITAL ##0 1;
    endproperty
    a_dig_refused: assert property (p_dig_refused) else $error("digital in ets");
    property p_start;
        @(posedge i_clk) disable iff (i_reset)
        state_reg == ATS_IDLE && init_reg && !abort_reg && !(ets_allowed && mode == ATS_TRG_DIGITAL)
        |=> state_reg == ATS_WAIT_START;
    endproperty
    a_start: assert property (p_start) else $error("no start wait");
    property p_delay;
        @(posedge i_clk) disable iff (i_reset || abort_reg)
        state_reg == ATS_WAIT_REF && trig |=> cnt_reg == delay_reg;
    endproperty
    a_delay: assert property (p_delay) else $error("delay not loaded");
    c_done: cover property (@(posedge i_clk) state_reg == ATS_DONE);
    c_multi: cover property (@(posedge i_clk) state_reg == ATS_WAIT_ADV);
    c_hyst: cover property (@(posedge i_clk) mode == ATS_TRG_HYST && raw_trig);
endmodule

// [dv/ats_sig_model.sv]
`timescale 1ns/100ps
module ats_sig_model (
    // Clock
    input wire logic i_clk,
    // Bench commands
    input wire logic [11:0] i_target,
    input wire logic i_dig_req,
    // Into the block
    output logic [11:0] o_sample,
    output logic o_dig_trig
);
    initial o_sample = 12'h0b4;
    // Slew so each crossing spans several samples
    always @(posedge i_clk)
    begin
        if (o_sample + 12'h008 <= i_target)
            o_sample <= o_sample + 12'h008;
        else if (o_sample >= i_target + 12'h008)
            o_sample <= o_sample - 12'h008;
        else
            o_sample <= i_target;
    end
    // Pin edge lands away from the clock edge
    assign #3 o_dig_trig = i_dig_req;
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
`include "ats_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb;
    import ats_pkg::*;
    logic i_clk = 0;
    logic i_reset = 1;
    logic [7:0] awaddr = 0;
    logic [7:0] araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, dig_req = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, capture, rec_done, dig_trig;
    logic [1:0] bresp, rresp;
    logic [11:0] target = 12'h0b4, sample, eq_sample;
    ats_status_t status;
    int error_cnt = 0;
    int samples_checked = 0;
    ats_sequencer u_ats_sequencer (.i_clk(i_clk), .i_reset(i_reset), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_sample(sample), .i_dig_trig(dig_trig), .o_capture(capture),
        .o_eq_sample(eq_sample), .o_record_done(rec_done), .o_status(status));
    ats_sig_model u_ats_sig_model (.i_clk(i_clk), .i_target(target), .i_dig_req(dig_req),
        .o_sample(sample), .o_dig_trig(dig_trig));
    always #5 i_clk = ~i_clk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge i_clk);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1;
                awvalid <= 0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1;
                wvalid <= 0;
            end
        end
        while (bvalid !== 1'b1)
            @(posedge i_clk);
        bready <= 0;
        `CHK(bresp, `ATS_RESP_OKAY)
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
            @(posedge i_clk);
        while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1)
            @(posedge i_clk);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task automatic wait_done(input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (rec_done !== 1'b1 && n < lim);
    endtask
    task automatic arm(input logic [31:0] trig, input logic [31:0] lvl);
        wr(`ATS_A_TRIG, trig);
        wr(`ATS_A_LEVEL, lvl);
        wr(`ATS_A_CTRL, 32'h0000_0005);
    endtask
    task automatic fire(input logic [31:0] trig, lvl, dly, input logic [11:0] up,
        output int n);
        wr(`ATS_A_DELAY, dly);
        target <= 12'h0b4;
        arm(trig, lvl);
        repeat (150) @(posedge i_clk);
        target <= up;
        wait_done(300, n);
    endtask
    task automatic t_reset;
        logic [7:0] adr [10] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
            8'h24, 8'h28};
        logic [31:0] ex [10] = '{32'h4, 32'h18, 32'h3e8, 32'h32, 32'h1, 32'h0, 32'h0,
            32'h0, 32'h0008_0000, 32'h0};
        logic [31:0] d;
        logic [1:0] r;
        `CHK(status, ATS_ST_UNKNOWN)
        for (int i = 0; i < 10; i++)
        begin
            rd(adr[i], d, r);
            `CHK(d, ex[i])
        end
        rd(8'h30, d, r);
        `CHK(r, `ATS_RESP_SLVERR)
        `CHK(d, 32'h0)
    endtask
    task automatic t_multi;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr(`ATS_A_RECLEN, 32'd10);
        wr(`ATS_A_NREC, 32'd3);
        arm(32'h18, 32'h0);
        repeat (3)
        begin
            wait_done(200, n);
            `CHK(n < 200, 1'b1)
        end
        @(posedge i_clk);
        `CHK(status, ATS_ST_COMPLETE)
        rd(`ATS_A_STATUS, d, r);
        `CHK(d[31:16], 16'h0003)
        // Advance by trigger, masked by a long holdoff
        wr(`ATS_A_HOLDOFF, 32'd100);
        wr(`ATS_A_NREC, 32'd2);
        arm(32'h08, 32'h0);
        wait_done(200, n);
        wait_done(200, n);
        `CHK(n > 100 && n < 200, 1'b1)
        wr(`ATS_A_HOLDOFF, 32'h0);
        wr(`ATS_A_NREC, 32'd1);
    endtask
    task automatic t_trig;
        logic [31:0] d;
        logic [1:0] r;
        int n, n0;
        wr(`ATS_A_RECLEN, 32'd200);
        wr(`ATS_A_REFPOS, 32'd10);
        fire(32'h1a, 32'hc8, 0, 12'h12c, n);
        `CHK(n < 300, 1'b1)
        wr(`ATS_A_REFPOS, 32'd50);
        target <= 12'h0b4;
        arm(32'h1a, 32'hc8);
        repeat (60) @(posedge i_clk);
        target <= 12'h12c;
        wait_done(300, n);
        `CHK(n, 300)
        `CHK(status, ATS_ST_IN_PROGRESS)
        target <= 12'h0b4;
        repeat (30) @(posedge i_clk);
        target <= 12'h12c;
        wait_done(300, n);
        `CHK(n < 300, 1'b1)
        fire(32'h1a, 32'hc8, 0, 12'h12c, n0);
        fire(32'h1a, 32'hc8, 32'd20, 12'h12c, n);
        `CHK(n - n0, 20)
        fire(32'h1e, 32'hc8, 0, 12'h12c, n);
        `CHK(n, 300)
        target <= 12'h064;
        wait_done(300, n);
        `CHK(n < 300, 1'b1)
        target <= 12'h12c;
        repeat (40) @(posedge i_clk);
        fire(32'h1b, 32'h0032_00c8, 0, 12'h12c, n);
        `CHK(n, 300)
        target <= 12'h064;
        repeat (40) @(posedge i_clk);
        target <= 12'h12c;
        wait_done(300, n);
        `CHK(n < 300, 1'b1)
        arm(32'h19, 32'h0);
        repeat (150) @(posedge i_clk);
        dig_req <= 1;
        repeat (4) @(posedge i_clk);
        dig_req <= 0;
        wait_done(300, n);
        `CHK(n < 300, 1'b1)
        // Leave digital mode before equivalent time is allowed
        wr(`ATS_A_TRIG, 32'h1a);
        wr(`ATS_A_CTRL, 32'h8);
        wr(`ATS_A_TRIG, 32'h19);
        rd(`ATS_A_TRIG, d, r);
        `CHK(d, 32'h1a)
        rd(`ATS_A_STATUS, d, r);
        `CHK(d[3], 1'b1)
        wr(`ATS_A_CTRL, 32'hc);
        wr(`ATS_A_TRIG, 32'h19);
        rd(`ATS_A_TRIG, d, r);
        `CHK(d, 32'h19)
    endtask
    task automatic t_abort_eq;
        logic [31:0] d;
        logic [1:0] r;
        wr(`ATS_A_CTRL, 32'h4);
        arm(32'h1a, 32'hc8);
        repeat (20) @(posedge i_clk);
        `CHK(status, ATS_ST_IN_PROGRESS)
        wr(`ATS_A_CTRL, 32'h6);
        // Capture flag trails the state by one register stage
        repeat (2) @(posedge i_clk);
        `CHK(status, ATS_ST_UNKNOWN)
        `CHK(capture, 1'b0)
        wr(`ATS_A_BW, 32'hffff_ffff);
        rd(`ATS_A_BW, d, r);
        `CHK(d, `ATS_BW_FULL)
        for (int i = 0; i < 8; i++)
            wr(8'h40 + 8'(4 * i), 32'h0);
        wr(`ATS_A_EQ, 32'h1);
        repeat (20) @(posedge i_clk);
        `CHK(eq_sample, 12'h000)
        wr(`ATS_A_EQ, 32'h0);
        repeat (20) @(posedge i_clk);
        `CHK(eq_sample, sample)
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_reset <= 0;
        t_reset();
        t_multi();
        t_trig();
        t_abort_eq();
        wrap_up();
    end
    // Watchdog: all scenarios need well under this
    initial
    begin
        repeat (60000) @(posedge i_clk);
        error_cnt++;
        wrap_up();
    end
endmodule
